/* inc/crcchk_pkg.sv */
/*
 * crcchk_pkg: shared constants, carrier types and the crc step function for
 * the crc16 rom checker.
 * assumes: apb with 32-bit data, one register per aligned word, byte address
 * equal to four times the register index.
 */
package crcchk_pkg;

    // register indices; byte address is index * 4
    localparam logic [15:0] CRCCHK_IDX_INPUT   = 16'h4021;
    localparam logic [15:0] CRCCHK_IDX_CONTROL = 16'h4022;
    localparam logic [15:0] CRCCHK_IDX_RESULT  = 16'h4023;
    localparam logic [15:0] CRCCHK_IDX_START   = 16'h4024;
    localparam logic [15:0] CRCCHK_IDX_COUNT   = 16'h4025;

    // control field positions
    localparam int CRCCHK_BIT_PTR    = 0;
    localparam int CRCCHK_BIT_LAUNCH = 1;
    localparam int CRCCHK_BIT_INITSEL = 2;
    localparam int CRCCHK_BIT_INIT   = 3;
    localparam int CRCCHK_BIT_DONE   = 4;

    // reset and init values
    localparam logic [15:0] CRCCHK_INIT_ZERO  = 16'h0000;
    localparam logic [15:0] CRCCHK_INIT_ONES  = 16'hFFFF;
    localparam logic [15:0] CRCCHK_RESULT_RST = 16'h0000;
    localparam logic [6:0]  CRCCHK_SECTOR_RST = 7'h00;
    localparam logic [6:0]  CRCCHK_LAST_SECTOR = 7'h7F;
    localparam logic [15:0] CRCCHK_POLY       = 16'h1021;

    // rom geometry: 128 sectors of 128 bytes
    localparam int CRCCHK_SECTOR_BITS = 7;
    localparam int CRCCHK_ROM_AW      = 14;
    localparam int CRCCHK_APB_AW      = 18;

    typedef struct packed {
        logic                     psel;
        logic                     penable;
        logic                     pwrite;
        logic [CRCCHK_APB_AW-1:0] paddr;
        logic [31:0]              pwdata;
    } crcchk_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } crcchk_apb_rsp_type;

    typedef enum logic [1:0] {
        CRCCHK_ST_IDLE  = 2'b00,
        CRCCHK_ST_RUN   = 2'b01,
        CRCCHK_ST_DRAIN = 2'b10
    } crcchk_state_type;

    // one byte folded into the crc, msb first, all eight shifts in one cycle
    function automatic logic [15:0] crcchk_step(input logic [15:0] crc,
                                                input logic [7:0]  data);
        logic [15:0] c;
        c = crc ^ {data, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ({c[14:0], 1'b0} ^ CRCCHK_POLY) : {c[14:0], 1'b0};
        end
        return c;
    endfunction : crcchk_step

endpackage : crcchk_pkg

/* rtl/crcchk_top.sv */
/*
 * crcchk_top: crc16 engine with a byte-at-a-time mode and a rom sector batch
 * mode, reached over apb.
 * assumes: rom read port on the same clock with one cycle of read latency;
 * apb master on i_clk_sys; one asynchronous active-low reset.
 */
// How it works
// - done flag low only while batch runs
// - init bit gives one-cycle pulse, reads zero
// - init loads 0x0000 or 0xFFFF per select
// - launch bit starts batch from start sector
// - pointer picks low or high result byte
// - result writes preset the pointed byte
// - input byte write folds into result, reads zero
// - start sector times 128 is first byte
// - count gives offset to last sector
// - polynomial 0x1021, ccitt-false style
// - one byte folded per clock cycle
// - range clamped at final sector 0x7F
`timescale 1ns/1ps
`default_nettype none

module crcchk_top
    import crcchk_pkg::*;
(
    input  wire logic                     i_clk_sys,  // 20 mhz system clock
    input  wire logic                     i_arst_n,   // async reset, active low
    input  wire crcchk_apb_req_type       i_apb_req,  // apb request group
    output var crcchk_apb_rsp_type        o_apb_rsp,  // apb answer group
    output logic                          o_rom_rd,   // rom read strobe
    output logic [CRCCHK_ROM_AW-1:0]      o_rom_addr, // rom byte address
    input  wire logic [7:0]               i_rom_data  // rom data, one cycle late
);

    logic [15:0]              result_q;
    logic                     ptr_q;
    logic                     launch_q;
    logic                     initsel_q;
    logic                     init_pulse_q;
    logic [6:0]               start_q;
    logic [6:0]               count_q;
    crcchk_state_type         state_q;
    logic [CRCCHK_ROM_AW-1:0] addr_q;
    logic [CRCCHK_ROM_AW-1:0] last_addr_q;
    logic                     data_vld_q;
    logic                     access;
    logic                     wr;
    logic [15:0]              idx;
    logic                     mapped;
    logic                     busy;
    logic                     launch_go;
    logic [7:0]               sect_sum;
    logic [6:0]               last_sect;
    logic [7:0]               rd_byte;

    // apb decode; zero wait states keeps the cpu model simple
    assign access = i_apb_req.psel & i_apb_req.penable;
    assign wr     = access & i_apb_req.pwrite;
    assign idx    = i_apb_req.paddr[CRCCHK_APB_AW-1:2];
    assign mapped = (idx >= CRCCHK_IDX_INPUT) && (idx <= CRCCHK_IDX_COUNT);
    assign busy   = (state_q != CRCCHK_ST_IDLE);

    // a launch while a batch runs is dropped, the running one owns the rom
    assign launch_go = wr && (idx == CRCCHK_IDX_CONTROL)
                       && i_apb_req.pwdata[CRCCHK_BIT_LAUNCH] && !busy;

    // last sector clamped so the batch never walks off the rom
    assign sect_sum  = {1'b0, start_q} + {1'b0, count_q};
    assign last_sect = sect_sum[7] ? CRCCHK_LAST_SECTOR : sect_sum[6:0];

    // control bits; launch is stored as written and software relies on
    // writing it alone, so no merging with other fields is attempted
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ptr_q     <= 1'b0;
            launch_q  <= 1'b0;
            initsel_q <= 1'b0;
        end else if (wr && idx == CRCCHK_IDX_CONTROL) begin // launch comes in its own write
            ptr_q     <= i_apb_req.pwdata[CRCCHK_BIT_PTR];
            launch_q  <= i_apb_req.pwdata[CRCCHK_BIT_LAUNCH];
            initsel_q <= i_apb_req.pwdata[CRCCHK_BIT_INITSEL];
        end
    end

    // init trigger is never stored, only pulsed for one cycle
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            init_pulse_q <= 1'b0;
        end else begin
            init_pulse_q <= wr && (idx == CRCCHK_IDX_CONTROL)
                            && i_apb_req.pwdata[CRCCHK_BIT_INIT];
        end
    end

    // sector range registers
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            start_q <= CRCCHK_SECTOR_RST;
            count_q <= CRCCHK_SECTOR_RST;
        end else if (wr) begin
            if (idx == CRCCHK_IDX_START) begin
                start_q <= i_apb_req.pwdata[6:0];
            end
            if (idx == CRCCHK_IDX_COUNT) begin
                count_q <= i_apb_req.pwdata[6:0];
            end
        end
    end

    // batch sequencer: issue addresses one per cycle, then drain the last byte
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q     <= CRCCHK_ST_IDLE;
            addr_q      <= '0;
            last_addr_q <= '0;
        end else begin
            case (state_q)
                CRCCHK_ST_IDLE: begin
                    if (launch_go) begin
                        state_q     <= CRCCHK_ST_RUN;
                        addr_q      <= {start_q, 7'h00};
                        last_addr_q <= {last_sect, 7'h7F};
                    end
                end
                CRCCHK_ST_RUN: begin
                    if (addr_q == last_addr_q) begin
                        state_q <= CRCCHK_ST_DRAIN;
                    end else begin
                        addr_q <= addr_q + 14'h0001;
                    end
                end
                CRCCHK_ST_DRAIN: begin
                    if (data_vld_q) begin
                        state_q <= CRCCHK_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= CRCCHK_ST_IDLE;
                end
            endcase
        end
    end

    assign o_rom_rd   = (state_q == CRCCHK_ST_RUN);
    assign o_rom_addr = addr_q;

    // rom data arrives one cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            data_vld_q <= 1'b0;
        end else begin
            data_vld_q <= o_rom_rd;
        end
    end

    // result: init beats batch beats cpu; cpu writes are ignored mid-batch
    // so a stray store cannot corrupt the rom checksum
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            result_q <= CRCCHK_RESULT_RST;
        end else if (init_pulse_q) begin
            result_q <= initsel_q ? CRCCHK_INIT_ONES : CRCCHK_INIT_ZERO;
        end else if (data_vld_q) begin
            result_q <= crcchk_step(result_q, i_rom_data);
        end else if (wr && !busy && idx == CRCCHK_IDX_INPUT) begin
            result_q <= crcchk_step(result_q, i_apb_req.pwdata[7:0]);
        end else if (wr && !busy && idx == CRCCHK_IDX_RESULT) begin
            if (ptr_q) begin
                result_q[15:8] <= i_apb_req.pwdata[7:0];
            end else begin
                result_q[7:0] <= i_apb_req.pwdata[7:0];
            end
        end
    end

    // read mux; input byte and reserved bits read as zero
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            CRCCHK_IDX_INPUT: begin
                rd_byte = 8'h00;
            end
            CRCCHK_IDX_CONTROL: begin
                rd_byte = {3'b000, !busy, 1'b0, initsel_q, launch_q, ptr_q};
            end
            CRCCHK_IDX_RESULT: begin
                rd_byte = ptr_q ? result_q[15:8] : result_q[7:0];
            end
            CRCCHK_IDX_START: begin
                rd_byte = {1'b0, start_q};
            end
            CRCCHK_IDX_COUNT: begin
                rd_byte = {1'b0, count_q};
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    assign o_apb_rsp.prdata  = {24'h000000, rd_byte};
    assign o_apb_rsp.pready  = 1'b1;
    assign o_apb_rsp.pslverr = access & !mapped; // unmapped index answers an error

    // checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);

    done_flag_a: assert property (
        launch_go |=> busy [*8]
    ) else $error("batch ended too early or never started");

    init_pulse_a: assert property (
        init_pulse_q |=> !init_pulse_q
    ) else $error("init pulse longer than one cycle");

    init_value_a: assert property (
        init_pulse_q |=> result_q == ($past(initsel_q) ? CRCCHK_INIT_ONES : CRCCHK_INIT_ZERO)
    ) else $error("wrong crc init value");

    batch_start_a: assert property (
        launch_go |=> o_rom_rd && o_rom_addr == {$past(start_q), 7'h00}
    ) else $error("batch did not start at first sector byte");

    ptr_read_a: assert property (
        access && !i_apb_req.pwrite && idx == CRCCHK_IDX_RESULT
        |-> o_apb_rsp.prdata[7:0] == (ptr_q ? result_q[15:8] : result_q[7:0])
    ) else $error("result byte pointer ignored");

    din_fold_a: assert property (
        wr && !busy && idx == CRCCHK_IDX_INPUT
        |=> result_q == crcchk_step($past(result_q), $past(i_apb_req.pwdata[7:0]))
    ) else $error("input byte not folded into result");

    clamp_last_a: assert property (
        launch_go |=> last_addr_q[13:7] == $past(last_sect) && last_addr_q[6:0] == 7'h7F
    ) else $error("batch end sector wrong");

    ascend_addr_a: assert property (
        o_rom_rd && $past(o_rom_rd) |-> o_rom_addr == $past(o_rom_addr) + 14'h0001
    ) else $error("rom fetch not ascending");

    batch_done_a: assert property (
        o_rom_rd && o_rom_addr == last_addr_q |=> ##1 !busy
    ) else $error("done not raised after last byte");

    // checker helpers: batch length measured apart from the sequencer,
    // so a sequencer that stops early or late shows up as a count mismatch
    logic [14:0] run_len_q; // busy cycles since launch
    logic [14:0] span_q;    // bytes the batch should fetch

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_len_q <= '0;
            span_q    <= '0;
        end else if (launch_go) begin
            run_len_q <= '0;
            span_q    <= {1'b0, last_sect, 7'h7F} - {1'b0, start_q, 7'h00} + 15'h0001;
        end else if (busy) begin
            run_len_q <= run_len_q + 15'h0001;
        end
    end

    batch_length_a: assert property (
        $fell(busy) |-> run_len_q == span_q + 15'h0001
    ) else $error("batch busy time does not match its range");

    done_read_a: assert property (
        access && !i_apb_req.pwrite && idx == CRCCHK_IDX_CONTROL
        |-> o_apb_rsp.prdata[CRCCHK_BIT_DONE] == (state_q == CRCCHK_ST_IDLE)
    ) else $error("done flag reads wrong");

    init_reads_zero_a: assert property (
        access && !i_apb_req.pwrite && idx == CRCCHK_IDX_CONTROL
        |-> o_apb_rsp.prdata[CRCCHK_BIT_INIT] == 1'b0
    ) else $error("init trigger does not read zero");

    rom_in_batch_a: assert property (
        o_rom_rd |-> busy
    ) else $error("rom fetched outside a batch");

    ptr_hi_write_a: assert property (
        wr && !busy && !init_pulse_q && idx == CRCCHK_IDX_RESULT && ptr_q
        |=> result_q[15:8] == $past(i_apb_req.pwdata[7:0])
            && result_q[7:0] == $past(result_q[7:0])
    ) else $error("high result byte preset wrong");

    ptr_lo_write_a: assert property (
        wr && !busy && !init_pulse_q && idx == CRCCHK_IDX_RESULT && !ptr_q
        |=> result_q[7:0] == $past(i_apb_req.pwdata[7:0])
            && result_q[15:8] == $past(result_q[15:8])
    ) else $error("low result byte preset wrong");

    din_reads_zero_a: assert property (
        access && !i_apb_req.pwrite && idx == CRCCHK_IDX_INPUT
        |-> o_apb_rsp.prdata == 32'h00000000
    ) else $error("input byte register does not read zero");

    sector_load_a: assert property (
        wr && idx == CRCCHK_IDX_START |=> start_q == $past(i_apb_req.pwdata[6:0])
    ) else $error("start sector not stored");

    count_load_a: assert property (
        wr && idx == CRCCHK_IDX_COUNT |=> count_q == $past(i_apb_req.pwdata[6:0])
    ) else $error("sector offset not stored");

    fetch_range_a: assert property (
        o_rom_rd |-> o_rom_addr <= last_addr_q
    ) else $error("rom fetch past the batch end");

    cov_batch_c: cover property (launch_go ##[1:300] !busy);
    cov_clamp_c: cover property (launch_go && sect_sum[7]);
    cov_init_c: cover property (init_pulse_q && initsel_q);
    cov_din_c: cover property (wr && idx == CRCCHK_IDX_INPUT);

endmodule : crcchk_top

`default_nettype wire

/* test/crcchk_rom_model.sv */
/*
 * crcchk_rom_model: behavioural program rom at the far side of the checker.
 * assumes one cycle of read latency on the system clock, as the engine expects.
 */
`timescale 1ns/1ps
`default_nettype none

module crcchk_rom_model
    import crcchk_pkg::*;
(
    input  wire logic                     i_clk_sys,  // system clock
    input  wire logic                     i_rom_rd,   // read strobe
    input  wire logic [CRCCHK_ROM_AW-1:0] i_rom_addr, // byte address
    output logic [7:0]                    o_rom_data  // data, one cycle late
);
    // pattern mixes offset and sector so a wrong sector shows up;
    // idle cycles toggle the bus so stale data never looks valid
    always_ff @(posedge i_clk_sys) begin
        if (i_rom_rd) begin
            o_rom_data <= i_rom_addr[7:0] ^ {i_rom_addr[13:7], 1'b1};
        end else begin
            o_rom_data <= ~o_rom_data;
        end
    end
endmodule : crcchk_rom_model

`default_nettype wire

/* test/tb_crc16_rom_checker.sv */
/*
 * tb_crc16_rom_checker: apb-driven bench for the crc16 rom checker.
 * assumes the rom model above and zero-wait apb answers (waits are bounded).
 */
`timescale 1ns/1ps
`default_nettype none

module tb_crc16_rom_checker
    import crcchk_pkg::*;
;
    logic                     i_clk_sys;
    logic                     i_arst_n;
    crcchk_apb_req_type       req;
    crcchk_apb_rsp_type       rsp;
    logic                     rom_rd;
    logic [CRCCHK_ROM_AW-1:0] rom_addr;
    logic [7:0]               rom_data;
    logic [31:0]              rdat;
    logic                     rerr;
    logic [15:0]              exp_crc;
    int                       num_errors;
    int                       cmp_count;

    // bytes folded in single-byte mode, first byte in the top bits
    localparam logic [23:0] DIN_SEQ = 24'h6300FF;

    crcchk_top u_dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_apb_req(req),
        .o_apb_rsp(rsp), .o_rom_rd(rom_rd), .o_rom_addr(rom_addr), .i_rom_data(rom_data));
    crcchk_rom_model u_rom (.i_clk_sys(i_clk_sys), .i_rom_rd(rom_rd),
        .i_rom_addr(rom_addr), .o_rom_data(rom_data));

    // 20 mhz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    // reference fold, msb first, written apart from the design
    function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ CRCCHK_POLY) : (c << 1);
        return c;
    endfunction : fold

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: data got %h expected %h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_err(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: slverr got %h expected %h", $time, got, exp);
        end
    endtask : chk_err

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        @(posedge i_clk_sys);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= {idx, 2'b00};
        req.pwdata  <= {24'h0, wd};
        @(posedge i_clk_sys);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        if (rsp.pready !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
    endtask : apb

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk_data(rdat, {24'h0, exp});
    endtask : rchk

    // result read through both pointer settings; base keeps launch low
    task automatic res_chk(input logic [7:0] base, input logic [15:0] exp);
        wr(CRCCHK_IDX_CONTROL, base);
        rchk(CRCCHK_IDX_RESULT, exp[7:0]);
        wr(CRCCHK_IDX_CONTROL, base | 8'h01);
        rchk(CRCCHK_IDX_RESULT, exp[15:8]);
    endtask : res_chk

    task automatic run_batch(input logic [6:0] s, input logic [6:0] cnt);
        int          n;
        logic [13:0] a;
        logic [7:0]  last;
        wr(CRCCHK_IDX_START, {1'b0, s});
        wr(CRCCHK_IDX_COUNT, {1'b0, cnt});
        rchk(CRCCHK_IDX_COUNT, {1'b0, cnt});
        wr(CRCCHK_IDX_CONTROL, 8'h0C);
        wr(CRCCHK_IDX_CONTROL, 8'h06);
        rchk(CRCCHK_IDX_CONTROL, 8'h06);
        n = 0;
        do begin
            apb(1'b0, CRCCHK_IDX_CONTROL, 8'h00);
            n++;
        end while (rdat[CRCCHK_BIT_DONE] !== 1'b1 && n < 400);
        chk_data(rdat, 32'h16);
        // a batch that never finishes has been counted above; stop here
        if (rdat[CRCCHK_BIT_DONE] !== 1'b1) begin
            print_verdict();
        end
        // clamp: never past the final sector
        last = ({1'b0, s} + {1'b0, cnt} > 8'h7F) ? 8'h7F : {1'b0, s} + {1'b0, cnt};
        exp_crc = CRCCHK_INIT_ONES;
        for (int i = s * 128; i <= last * 128 + 127; i++) begin
            a = i[13:0];
            exp_crc = fold(exp_crc, a[7:0] ^ {a[13:7], 1'b1});
        end
        res_chk(8'h04, exp_crc);
    endtask : run_batch

    initial begin
        i_arst_n   = 1'b0;
        req        = '0;
        num_errors = 0;
        cmp_count  = 0;
        repeat (10) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        rchk(CRCCHK_IDX_CONTROL, 8'h10);
        chk_err(rerr, 1'b0);
        rchk(CRCCHK_IDX_START, 8'h00);
        res_chk(8'h00, 16'h0000);
        wr(CRCCHK_IDX_CONTROL, 8'h0C);
        rchk(CRCCHK_IDX_CONTROL, 8'h14);
        res_chk(8'h04, CRCCHK_INIT_ONES);
        wr(CRCCHK_IDX_CONTROL, 8'h08);
        res_chk(8'h00, CRCCHK_INIT_ZERO);
        wr(CRCCHK_IDX_CONTROL, 8'h01);
        wr(CRCCHK_IDX_RESULT, 8'h12);
        wr(CRCCHK_IDX_CONTROL, 8'h00);
        wr(CRCCHK_IDX_RESULT, 8'h34);
        res_chk(8'h00, 16'h1234);
        // consecutive input writes three cycles apart: each fold must land before the next write
        exp_crc = 16'h1234;
        for (int k = 0; k < 3; k++) begin
            wr(CRCCHK_IDX_INPUT, DIN_SEQ[23 - 8 * k -: 8]);
            exp_crc = fold(exp_crc, DIN_SEQ[23 - 8 * k -: 8]);
        end
        rchk(CRCCHK_IDX_INPUT, 8'h00);
        res_chk(8'h00, exp_crc);
        apb(1'b0, 16'h4026, 8'h00);
        chk_err(rerr, 1'b1);
        run_batch(7'h02, 7'h01);
        run_batch(7'h7F, 7'h05);
        print_verdict();
    end
endmodule : tb_crc16_rom_checker

`default_nettype wire
